/* File: design/tlsq_sequencer.sv */
// multi-level trace control sequencer of the analyzer front end
`timescale 1ns/1ps
`default_nettype none

module tlsq_sequencer
  import tlsq_pkg::*;
#(
  parameter int DATA_W = 48
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // probe inputs from the target
  input wire logic probe_clk,
  input wire logic [DATA_W-1:0] probe_data,
  // run control
  input wire logic run_start,
  input wire logic run_abort,
  // per-level setup
  input wire logic [TLSQ_LEVELS-1:0][TLSQ_DLY_W-1:0] lvl_delay,
  input wire logic [TLSQ_LEVELS-1:0] lvl_count_patterns,
  input wire logic [TLSQ_LEVELS-1:0][TLSQ_LVL_W-1:0] lvl_end,
  input wire logic [TLSQ_LEVELS-1:0][TLSQ_LVL_W-1:0] lvl_jump_to,
  // per-level, per-command conditions
  input wire logic [TLSQ_LEVELS-1:0][TLSQ_CMDS-1:0][TLSQ_CODE_W-1:0] cmd_code,
  input wire logic [TLSQ_LEVELS-1:0][TLSQ_CMDS-1:0][DATA_W-1:0] cmd_pattern,
  input wire logic [TLSQ_LEVELS-1:0][TLSQ_CMDS-1:0][DATA_W-1:0] cmd_care,
  // acquisition memory write
  output logic store_we,
  output logic [DATA_W-1:0] store_data,
  output logic [TLSQ_LVL_W-1:0] store_level,
  // status
  output logic [TLSQ_LVL_W-1:0] status_level,
  output logic status_busy,
  output logic status_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and sample edge

  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;
  logic sample_tick;

  // data and clock travel the same two stages, so the target must hold data
  // a few system clocks around its sample edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
    end else begin
      clk_meta <= probe_clk;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= probe_data;
      data_sync <= data_meta;
    end
  end

  assign sample_tick = clk_sync && !clk_prev;

  ////////////////////////////////////////////////////////////////////////////
  // level state

  tlsq_state_t state;
  logic [TLSQ_LVL_W-1:0] level;
  logic [TLSQ_DLY_W-1:0] count;
  logic [TLSQ_CMDS-1:0] fire;
  logic [TLSQ_DLY_W-1:0] cur_count;
  logic count_inc;
  logic step;
  logic entered;
  logic [TLSQ_LVL_W-1:0] next_level;

  assign step = (state == TLSQ_ST_RUN) && sample_tick;

  // pattern-counting levels step only on samples that match the advance pattern
  assign count_inc = lvl_count_patterns[level]
                     ? (((data_sync ^ cmd_pattern[level][TLSQ_CMD_ADV])
                         & cmd_care[level][TLSQ_CMD_ADV]) == '0)
                     : 1'b1;

  // count seen by the conditions includes the current sample
  assign cur_count = (count_inc && count != TLSQ_CNT_MAX)
                     ? count + TLSQ_CNT_ONE : count;

  ////////////////////////////////////////////////////////////////////////////
  // command conditions, all against the same sample

  for (genvar c = 0; c < TLSQ_CMDS; c++) begin : g_cmd
    tlsq_cond #(
      .DATA_W(DATA_W)
    ) u_cond (
      .code(cmd_code[level][c]),
      .pattern(cmd_pattern[level][c]),
      .care(cmd_care[level][c]),
      .data(data_sync),
      .count(cur_count),
      .delay(lvl_delay[level]),
      .fire(fire[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer decision

  always_comb begin
    next_level = level;
    entered = 1'b0;
    if (fire[TLSQ_CMD_STOP]) begin
      next_level = level;
    end else if (fire[TLSQ_CMD_JUMP]) begin
      next_level = lvl_jump_to[level];
      entered = 1'b1;
    end else if (fire[TLSQ_CMD_ADV]) begin
      // past its end level a level wraps back to the first one
      next_level = (level == lvl_end[level]) ? TLSQ_LVL_FIRST
                   : level + TLSQ_LVL_STEP;
      entered = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= TLSQ_ST_IDLE;
    end else if (run_abort) begin
      state <= TLSQ_ST_IDLE;
    end else begin
      case (state)
        TLSQ_ST_IDLE, TLSQ_ST_DONE: begin
          if (run_start) begin
            state <= TLSQ_ST_RUN;
          end
        end
        TLSQ_ST_RUN: begin
          if (step && fire[TLSQ_CMD_STOP]) begin
            state <= TLSQ_ST_DONE;
          end
        end
        default: state <= TLSQ_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      level <= TLSQ_LVL_FIRST;
    end else if (state != TLSQ_ST_RUN && run_start && !run_abort) begin
      level <= TLSQ_LVL_FIRST;
    end else if (step) begin
      level <= next_level;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= TLSQ_CNT_ZERO;
    end else if (state != TLSQ_ST_RUN && run_start && !run_abort) begin
      count <= TLSQ_CNT_ZERO;
    end else if (step) begin
      count <= entered ? TLSQ_CNT_ZERO : cur_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trace store, kept apart from the transfer decision

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      store_we <= 1'b0;
      store_data <= '0;
      store_level <= TLSQ_LVL_FIRST;
    end else begin
      store_we <= step && fire[TLSQ_CMD_TRACE] && !run_abort;
      if (step) begin
        store_data <= data_sync;
        store_level <= level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status

  assign status_level = level;
  assign status_busy = (state == TLSQ_ST_RUN);
  assign status_ready = (state == TLSQ_ST_DONE);

endmodule : tlsq_sequencer

`default_nettype wire

/* File: design/tlsq_pkg.sv */
// constants and types shared by the trace level sequencer
//
// How it works
// - trace is decided on its own, apart from stop, jump and advance
// - stop outranks jump; a stopping sample never moves the level
// - each command picks a condition code: 1 always, 2 and 9 to F never, others data-qualified
// - per-level sample count restarts on entry and steps each sample clock, or only on advance-pattern matches if counting patterns
// - delay conditions need a pattern match plus the count relation to delay
// - jump may reach any level; advance only the next one, or level 0 from its end level
// - sixteen levels 0 to F, each with its own delay and end level
// - trace set to always stores every sample while the level waits
// - stop and trace both always: one sample stored, then halt
// - after halting, the stop level is shown with a ready flag
// - all commands judge the same sample; the move applies to the next
// - each delay is a 16-bit value counting clocks or pattern hits
// - busy with the current level while running, ready once stopped
`default_nettype none

package tlsq_pkg;
  localparam int TLSQ_LEVELS = 16;
  localparam int TLSQ_LVL_W = 4;
  localparam int TLSQ_DLY_W = 16;
  localparam int TLSQ_CODE_W = 4;
  localparam int TLSQ_CMDS = 4;

  // command slots inside one level
  localparam int TLSQ_CMD_STOP = 0;
  localparam int TLSQ_CMD_JUMP = 1;
  localparam int TLSQ_CMD_ADV = 2;
  localparam int TLSQ_CMD_TRACE = 3;

  // condition codes
  localparam logic [TLSQ_CODE_W-1:0] TLSQ_C_DATA = 4'h0;
  localparam logic [TLSQ_CODE_W-1:0] TLSQ_C_ALWAYS = 4'h1;
  localparam logic [TLSQ_CODE_W-1:0] TLSQ_C_NEVER = 4'h2;
  localparam logic [TLSQ_CODE_W-1:0] TLSQ_C_LT = 4'h3;
  localparam logic [TLSQ_CODE_W-1:0] TLSQ_C_LE = 4'h4;
  localparam logic [TLSQ_CODE_W-1:0] TLSQ_C_EQ = 4'h5;
  localparam logic [TLSQ_CODE_W-1:0] TLSQ_C_GE = 4'h6;
  localparam logic [TLSQ_CODE_W-1:0] TLSQ_C_GT = 4'h7;
  localparam logic [TLSQ_CODE_W-1:0] TLSQ_C_NE = 4'h8;

  localparam logic [TLSQ_LVL_W-1:0] TLSQ_LVL_FIRST = 4'h0;
  localparam logic [TLSQ_LVL_W-1:0] TLSQ_LVL_STEP = 4'h1;
  localparam logic [TLSQ_DLY_W-1:0] TLSQ_CNT_ZERO = 16'h0000;
  localparam logic [TLSQ_DLY_W-1:0] TLSQ_CNT_ONE = 16'h0001;
  localparam logic [TLSQ_DLY_W-1:0] TLSQ_CNT_MAX = 16'hFFFF;

  typedef enum logic [1:0] {
    TLSQ_ST_IDLE,
    TLSQ_ST_RUN,
    TLSQ_ST_DONE
  } tlsq_state_t;
endpackage : tlsq_pkg

`default_nettype wire

/* File: design/tlsq_cond.sv */
// one command condition: masked pattern match qualified by count and delay
`timescale 1ns/1ps
`default_nettype none

module tlsq_cond
  import tlsq_pkg::*;
#(
  parameter int DATA_W = 48
) (
  // condition setup
  input wire logic [TLSQ_CODE_W-1:0] code,
  input wire logic [DATA_W-1:0] pattern,
  input wire logic [DATA_W-1:0] care,
  // live values
  input wire logic [DATA_W-1:0] data,
  input wire logic [TLSQ_DLY_W-1:0] count,
  input wire logic [TLSQ_DLY_W-1:0] delay,
  // result
  output logic fire
);

  // cleared care bits drop out, so an all-don't-care pattern always matches
  function automatic logic masked_match(input logic [DATA_W-1:0] d,
                                        input logic [DATA_W-1:0] p,
                                        input logic [DATA_W-1:0] m);
    masked_match = ((d ^ p) & m) == '0;
  endfunction : masked_match

  logic hit;

  assign hit = masked_match(data, pattern, care);

  always_comb begin
    case (code)
      TLSQ_C_DATA: fire = hit;
      TLSQ_C_ALWAYS: fire = 1'b1;
      TLSQ_C_NEVER: fire = 1'b0;
      TLSQ_C_LT: fire = hit && (count < delay);
      TLSQ_C_LE: fire = hit && (count <= delay);
      TLSQ_C_EQ: fire = hit && (count == delay);
      TLSQ_C_GE: fire = hit && (count >= delay);
      TLSQ_C_GT: fire = hit && (count > delay);
      TLSQ_C_NE: fire = hit && (count != delay);
      default: fire = 1'b0;
    endcase
  end

endmodule : tlsq_cond

`default_nettype wire

/* File: verif/tlsq_target.sv */
// model of the probed target: one word per sample clock
`timescale 1ns/1ps
`default_nettype none

module tlsq_target #(
  parameter int DATA_W = 8
) (
  // clock
  input wire logic clk_sys,
  // probe pins
  output logic probe_clk,
  output logic [DATA_W-1:0] probe_data
);
  initial begin
    probe_clk = 1'b0;
    probe_data = '0;
  end

  // word settles 2 clocks before the rise and holds 4 after the fall, then the bus toggles
  task automatic send(input logic [DATA_W-1:0] w);
    @(posedge clk_sys) #1;
    probe_data = w;
    repeat (2) @(posedge clk_sys);
    #1 probe_clk = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 probe_clk = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 probe_data = ~w;
  endtask : send
endmodule : tlsq_target

`default_nettype wire

/* File: verif/tlsq_sequencer_assertions.sv */
// checker on the run control, store and status ports
`timescale 1ns/1ps
`default_nettype none

module tlsq_sequencer_assertions
  import tlsq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // run control
  input wire logic run_start,
  input wire logic run_abort,
  // results
  input wire logic store_we,
  input wire logic [TLSQ_LVL_W-1:0] status_level,
  input wire logic status_busy,
  input wire logic status_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_go;
    run_start && !run_abort && !status_busy;
  endsequence

  AST_START: assert property (s_go |=> status_busy && status_level == 4'h0) else $error("bad start");
  AST_EXCL: assert property (!(status_busy && status_ready)) else $error("busy with ready");
  AST_ABORT: assert property (run_abort |=> !status_busy && !status_ready) else $error("abort");
  AST_HOLD: assert property (status_ready && !run_start && !run_abort
    |=> status_ready && $stable(status_level)) else $error("stop level moved");
  AST_NO_STORE: assert property (!status_busy |=> !store_we) else $error("store when idle");
  AST_PULSE: assert property (store_we |=> !store_we) else $error("store too long");
  AST_READY_STEP: assert property ($rose(status_ready) |-> $past(status_busy)) else $error("rdy");
  AST_BUSY_ENDS: assert property (status_busy && !run_abort
    |=> status_busy || status_ready) else $error("busy lost");
endmodule : tlsq_sequencer_assertions

bind tlsq_sequencer tlsq_sequencer_assertions u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .run_start(run_start), .run_abort(run_abort), .store_we(store_we),
  .status_level(status_level), .status_busy(status_busy), .status_ready(status_ready));

`default_nettype wire

/* File: verif/trace_level_sequencer_test.sv */
// bench: one-word paths as rows, then delay, wrap, pattern-count and reset cases
`timescale 1ns/1ps
`default_nettype none

module trace_level_sequencer_test
  import tlsq_pkg::*;
;
  typedef struct packed {
    logic [7:0] w;
    logic [3:0] lvl;
    logic rdy;
    logic [3:0] n;
  } tlsq_row_t;
  tlsq_row_t rows [5] = '{
    '{8'h01, 4'h8, 1'b1, 4'h2},
    '{8'h10, 4'h1, 1'b1, 4'h2},
    '{8'h11, 4'h8, 1'b1, 4'h2},
    '{8'h33, 4'h0, 1'b1, 4'h1},
    '{8'h40, 4'h0, 1'b0, 4'h2}};
  // stop code on level 1, its delay, and samples on level 1 up to the stop
  typedef struct packed {
    logic [3:0] code;
    logic [15:0] d;
    logic [3:0] n;
  } tlsq_dly_row_t;
  tlsq_dly_row_t dly_rows [6] = '{
    '{TLSQ_C_LT, 16'h0002, 4'h1},
    '{TLSQ_C_LE, 16'h0001, 4'h1},
    '{TLSQ_C_EQ, 16'h0004, 4'h4},
    '{TLSQ_C_GE, 16'h0003, 4'h3},
    '{TLSQ_C_GT, 16'h0003, 4'h4},
    '{TLSQ_C_NE, 16'h0001, 4'h2}};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic run_start = 1'b0;
  logic run_abort = 1'b0;
  logic probe_clk;
  logic [7:0] probe_data;
  logic [TLSQ_LEVELS-1:0][TLSQ_DLY_W-1:0] lvl_delay;
  logic [TLSQ_LEVELS-1:0] lvl_count_patterns;
  logic [TLSQ_LEVELS-1:0][TLSQ_LVL_W-1:0] lvl_end;
  logic [TLSQ_LEVELS-1:0][TLSQ_LVL_W-1:0] lvl_jump_to;
  logic [TLSQ_LEVELS-1:0][TLSQ_CMDS-1:0][TLSQ_CODE_W-1:0] cmd_code;
  logic [TLSQ_LEVELS-1:0][TLSQ_CMDS-1:0][7:0] cmd_pattern;
  logic [TLSQ_LEVELS-1:0][TLSQ_CMDS-1:0][7:0] cmd_care;
  logic store_we;
  logic [7:0] store_data;
  logic [3:0] store_level;
  logic [3:0] status_level;
  logic status_busy;
  logic status_ready;
  int fails = 0;
  int total_checks = 0;
  int stores = 0;
  int base = 0;

  tlsq_target #(.DATA_W(8)) tgt (.clk_sys(clk_sys), .probe_clk(probe_clk),
    .probe_data(probe_data));
  tlsq_sequencer #(.DATA_W(8)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .probe_clk(probe_clk), .probe_data(probe_data), .run_start(run_start),
    .run_abort(run_abort), .lvl_delay(lvl_delay), .lvl_count_patterns(lvl_count_patterns),
    .lvl_end(lvl_end), .lvl_jump_to(lvl_jump_to), .cmd_code(cmd_code),
    .cmd_pattern(cmd_pattern), .cmd_care(cmd_care), .store_we(store_we),
    .store_data(store_data), .store_level(store_level), .status_level(status_level),
    .status_busy(status_busy), .status_ready(status_ready));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (store_we === 1'b1) stores <= stores + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // abort first so every run starts from a clean idle
  task automatic go;
    @(posedge clk_sys) #1;
    run_abort = 1'b1;
    @(posedge clk_sys) #1;
    run_abort = 1'b0;
    run_start = 1'b1;
    @(posedge clk_sys) #1;
    run_start = 1'b0;
    base = stores;
  endtask : go

  initial begin
    #20000;
    fails++;
    give_verdict();
  end

  initial begin
    lvl_delay = '0;
    lvl_count_patterns = '0;
    lvl_end = '1;
    lvl_jump_to = '0;
    cmd_pattern = '0;
    cmd_care = '1;
    for (int l = 0; l < 16; l++) cmd_code[l] = {4{TLSQ_C_NEVER}};
    cmd_code[0] = {TLSQ_C_ALWAYS, TLSQ_C_DATA, TLSQ_C_DATA, TLSQ_C_DATA};
    cmd_pattern[0] = {8'h00, 8'h10, 8'h01, 8'h33};
    cmd_care[0] = {8'hff, 8'h10, 8'h01, 8'hff};
    lvl_jump_to[0] = 4'h8;
    cmd_code[1] = {TLSQ_C_ALWAYS, TLSQ_C_NEVER, TLSQ_C_NEVER, TLSQ_C_ALWAYS};
    cmd_code[8] = cmd_code[1];
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    @(posedge clk_sys) #1;
    chk(16'(status_busy), 16'h0000);
    chk(16'(status_ready), 16'h0000);
    chk(16'(status_level), 16'h0000);
    foreach (rows[i]) begin
      go();
      tgt.send(rows[i].w);
      chk(16'(store_data), 16'(rows[i].w));
      chk(16'(store_level), 16'h0000);
      tgt.send(8'h00);
      repeat (4) @(posedge clk_sys);
      #1;
      chk(16'(status_level), 16'(rows[i].lvl));
      chk(16'(status_ready), 16'(rows[i].rdy));
      chk(16'(stores - base), 16'(rows[i].n));
    end
    cmd_care[1][TLSQ_CMD_STOP] = 8'h00;
    foreach (dly_rows[i]) begin
      cmd_code[1][TLSQ_CMD_STOP] = dly_rows[i].code;
      lvl_delay[1] = dly_rows[i].d;
      go();
      tgt.send(8'h10);
      repeat (dly_rows[i].n - 1) tgt.send(8'h5a);
      chk(16'(status_busy), 16'h0001);
      chk(16'(status_level), 16'h0001);
      tgt.send(8'h00);
      chk(16'(status_ready), 16'h0001);
      chk(16'(stores - base), 16'(dly_rows[i].n + 1));
      chk(16'(store_data), 16'h0000);
      chk(16'(store_level), 16'h0001);
    end
    // advance from a level equal to its end level wraps to level 0
    cmd_code[1] = {TLSQ_C_ALWAYS, TLSQ_C_ALWAYS, TLSQ_C_NEVER, TLSQ_C_NEVER};
    lvl_end[1] = 4'h1;
    go();
    tgt.send(8'h10);
    tgt.send(8'h5a);
    chk(16'(status_level), 16'h0000);
    chk(16'(status_busy), 16'h0001);
    // pattern-counting level: only words matching the advance pattern count
    cmd_code[1] = {TLSQ_C_ALWAYS, TLSQ_C_NEVER, TLSQ_C_NEVER, TLSQ_C_GE};
    lvl_delay[1] = 16'h0002;
    lvl_count_patterns[1] = 1'b1;
    cmd_pattern[1][TLSQ_CMD_ADV] = 8'h5a;
    cmd_care[1][TLSQ_CMD_ADV] = 8'hff;
    go();
    tgt.send(8'h10);
    tgt.send(8'h5a);
    tgt.send(8'h00);
    chk(16'(status_busy), 16'h0001);
    tgt.send(8'h5a);
    chk(16'(status_ready), 16'h0001);
    chk(16'(stores - base), 16'h0004);
    // reset in mid-run drops the sequencer back to idle at level 0
    go();
    tgt.send(8'h10);
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(16'(status_busy), 16'h0000);
    chk(16'(status_ready), 16'h0000);
    chk(16'(status_level), 16'h0000);
    chk(16'(store_data), 16'h0000);
    give_verdict();
  end
endmodule : trace_level_sequencer_test

`default_nettype wire
